// >>> logic/modebank_cfg.svh
`ifndef MODEBANK_CFG_SVH
`define MODEBANK_CFG_SVH
// Summary of operation
// - Mode bits are set through one address and cleared through another.
// - Only positions written with one change; zero positions stay as they are.
// - Leave-offline goes to passive idle, starts timers, clears enter-offline request.
// - End of interrupt clears itself as the interrupt drops; the output pin follows one edge later.
// - Enter-offline waits for the current request, goes offline, clears itself.
// - Leave-master forces the slave machine to await parameters, then clears.
// - Configuration accept swaps the buffers only while swap-enable is one.
// - Watchdog reload loads the user watchdog with its preset, then clears.
// - A read-only 16-bit status word, low and high byte at consecutive addresses.
// - Status bit 0 is zero when offline and one in passive idle.
// - Status bit 1 is one while a link indication is held.
// - Status bit 2 is one until the master fetches the diagnostics buffer.
// - RAM access at or above byte address 1536 is moved down 1024 and flagged in bit 3.
// - Status bits 5..4 give the slave machine state, code 11 never used.
// - Status bits 7..6 give the watchdog machine state, code 11 never used.
// - Status bits 11..8 give the detected baud rate code 0000 to 1001.
// - Status bits 15..12 hold a fixed release number.
// - After end of interrupt the output stays inactive at least the set gap.
// - After reset the interrupt output is low-active until polarity changes.

// Register indexes; byte address is four times the index
`define IDX_STAT_LO 10'h004
`define IDX_STAT_HI 10'h005
`define IDX_MODE_SET 10'h008
`define IDX_MODE_CLR 10'h009
`define IDX_IRQ_CFG 10'h00c
`define IDX_WDOG_PRESET 10'h00d

// Mode bit positions
`define MB_LEAVE_OFFLINE 0
`define MB_END_OF_IRQ 1
`define MB_GO_OFFLINE 2
`define MB_LEAVE_MASTER 3
`define MB_SWAP_EN 4
`define MB_WDOG_RELOAD 5
`define MODE_WIDTH 6

// Interrupt configuration bit positions
`define IC_INT_POL 0
`define IC_GAP_SCALE 1

// Reset values
`define MODE_RESET 6'h00
`define IRQ_CFG_RESET 2'h0
`define WDOG_PRESET_RESET 16'hffff
// Arbitrary release number
`define RELEASE_NUM 4'h1

// RAM limits in bytes
`define RAM_LIMIT 11'h600
`define RAM_FOLD 11'h400

// Timing
`define CLK_PERIOD_NS 25
`define IRQ_GAP_SHORT_NS 1000
`define IRQ_GAP_LONG_US 1000
`define IRQ_GAP_SHORT_CYC ((`IRQ_GAP_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_GAP_LONG_CYC ((`IRQ_GAP_LONG_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> logic/modebank_pkg.sv
package modebank_pkg;
  typedef enum logic [1:0] {AWAIT_PRM, AWAIT_CFG, CYCLIC_EXCHANGE} slave_state_type;
  typedef enum logic {OFFLINE, PASSIVE_IDLE} run_state_type;
  typedef struct packed {
    logic [3:0] release_num;
    logic [3:0] baud_code;
    logic [1:0] wdog_state;
    logic [1:0] slave_state;
    logic ram_violation;
    logic diag_pending;
    logic link_indication_pending;
    logic passive_idle;
  } status_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
endpackage

// >>> logic/modebank.sv
`timescale 1ns/1ps
`include "modebank_cfg.svh"
module modebank #(
  parameter int IRQ_GAP_LONG_CYCLES = `IRQ_GAP_LONG_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // APB slave
  input wire modebank_pkg::apb_req_type APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Protocol engine status
  input wire logic REQ_BUSY,
  input wire logic LINK_IND_PENDING,
  input wire logic DIAG_PENDING,
  input wire logic [1:0] WDOG_STATE,
  input wire logic [3:0] BAUD_CODE,
  input wire logic PRM_OK,
  input wire logic CFG_OK,
  input wire logic CFG_ACCEPT,
  // Host RAM window
  input wire logic RAM_STROBE,
  input wire logic [10:0] RAM_ADDR,
  output logic [10:0] RAM_ADDR_MAPPED,
  // Actions and interrupt
  input wire logic IRQ_EVENT,
  output logic TIMERS_START,
  output logic CFG_SWAP,
  output logic USER_WDOG_EXPIRED,
  output logic OFFLINE_ENTERED,
  output logic IRQ_OUT
);
  import modebank_pkg::*;

  localparam logic [15:0] GAP_SHORT = 16'(`IRQ_GAP_SHORT_CYC);
  localparam logic [15:0] GAP_LONG = 16'(IRQ_GAP_LONG_CYCLES);

  logic [`MODE_WIDTH-1:0] mode_reg;
  logic [`MODE_WIDTH-1:0] mode_next;
  logic [`MODE_WIDTH-1:0] hw_clear;
  logic [1:0] irq_cfg_reg;
  logic [15:0] wdog_preset_reg;
  logic [15:0] wdog_cnt_reg;
  logic [15:0] gap_cnt_reg;
  logic irq_active_reg;
  logic ram_violation_reg;
  logic [31:0] prdata_reg;
  run_state_type run_reg;
  slave_state_type slave_reg;
  status_type status;
  logic setup_phase;
  logic access_phase;
  logic wr_set;
  logic wr_clr;
  logic wr_cfg;
  logic wr_preset;
  logic mapped;
  logic ram_over;

  // Byte address of a register index
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    return addr == {idx, 2'b00};
  endfunction

  // APB phases; the slave never inserts wait states
  assign setup_phase = APB_REQ.psel && !APB_REQ.penable;
  assign access_phase = APB_REQ.psel && APB_REQ.penable;
  assign PREADY = 1'b1;
  assign PRDATA = prdata_reg;

  // Address decode shared by reads, writes and the error answer
  assign mapped = hit(APB_REQ.paddr, `IDX_STAT_LO) || hit(APB_REQ.paddr, `IDX_STAT_HI)
    || hit(APB_REQ.paddr, `IDX_MODE_SET) || hit(APB_REQ.paddr, `IDX_MODE_CLR)
    || hit(APB_REQ.paddr, `IDX_IRQ_CFG) || hit(APB_REQ.paddr, `IDX_WDOG_PRESET);
  assign PSLVERR = access_phase && !mapped;

  // Writes land only at the completing access edge
  assign wr_set = access_phase && APB_REQ.pwrite && hit(APB_REQ.paddr, `IDX_MODE_SET);
  assign wr_clr = access_phase && APB_REQ.pwrite && hit(APB_REQ.paddr, `IDX_MODE_CLR);
  assign wr_cfg = access_phase && APB_REQ.pwrite && hit(APB_REQ.paddr, `IDX_IRQ_CFG);
  assign wr_preset = access_phase && APB_REQ.pwrite && hit(APB_REQ.paddr, `IDX_WDOG_PRESET);

  // Status word assembly
  always_comb begin
    status.passive_idle = (run_reg == PASSIVE_IDLE);
    status.link_indication_pending = LINK_IND_PENDING;
    status.diag_pending = DIAG_PENDING;
    status.ram_violation = ram_violation_reg;
    status.slave_state = slave_reg;
    status.wdog_state = WDOG_STATE;
    status.baud_code = BAUD_CODE;
    status.release_num = `RELEASE_NUM;
  end

  // Read data is captured in the setup cycle, so it is stable in the access cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0;
    end else if (setup_phase && !APB_REQ.pwrite) begin
      if (hit(APB_REQ.paddr, `IDX_STAT_LO)) begin
        prdata_reg <= {24'h0, status[7:0]};
      end else if (hit(APB_REQ.paddr, `IDX_STAT_HI)) begin
        prdata_reg <= {24'h0, status[15:8]};
      end else if (hit(APB_REQ.paddr, `IDX_MODE_SET) || hit(APB_REQ.paddr, `IDX_MODE_CLR)) begin
        prdata_reg <= {26'h0, mode_reg};
      end else if (hit(APB_REQ.paddr, `IDX_IRQ_CFG)) begin
        prdata_reg <= {30'h0, irq_cfg_reg};
      end else if (hit(APB_REQ.paddr, `IDX_WDOG_PRESET)) begin
        prdata_reg <= {16'h0, wdog_preset_reg};
      end else begin
        prdata_reg <= 32'h0;
      end
    end
  end

  // Hardware clears each action bit once its action is taken
  always_comb begin
    hw_clear = '0;
    hw_clear[`MB_LEAVE_OFFLINE] = mode_reg[`MB_LEAVE_OFFLINE];
    hw_clear[`MB_END_OF_IRQ] = mode_reg[`MB_END_OF_IRQ];
    hw_clear[`MB_GO_OFFLINE] = (mode_reg[`MB_GO_OFFLINE] && !REQ_BUSY)
      || mode_reg[`MB_LEAVE_OFFLINE];
    hw_clear[`MB_LEAVE_MASTER] = mode_reg[`MB_LEAVE_MASTER];
    hw_clear[`MB_WDOG_RELOAD] = mode_reg[`MB_WDOG_RELOAD];
  end

  // Set wins over any clear in the same cycle; bits 7 and 6 are dropped
  always_comb begin
    mode_next = mode_reg & ~hw_clear;
    if (wr_clr) begin
      mode_next = mode_next & ~APB_REQ.pwdata[`MODE_WIDTH-1:0];
    end
    if (wr_set) begin
      mode_next = mode_next | APB_REQ.pwdata[`MODE_WIDTH-1:0];
    end
  end

  // Mode register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_reg <= `MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Own configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_cfg_reg <= `IRQ_CFG_RESET;
      wdog_preset_reg <= `WDOG_PRESET_RESET;
    end else begin
      if (wr_cfg) begin
        irq_cfg_reg <= APB_REQ.pwdata[1:0];
      end
      if (wr_preset) begin
        wdog_preset_reg <= APB_REQ.pwdata[15:0];
      end
    end
  end

  // Offline and passive idle; a pending go-offline waits for the engine to go quiet
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      run_reg <= OFFLINE;
      TIMERS_START <= 1'b0;
      OFFLINE_ENTERED <= 1'b0;
    end else begin
      TIMERS_START <= 1'b0;
      OFFLINE_ENTERED <= 1'b0;
      if (mode_reg[`MB_LEAVE_OFFLINE] && run_reg == OFFLINE) begin
        run_reg <= PASSIVE_IDLE;
        TIMERS_START <= 1'b1;
      end else if (mode_reg[`MB_GO_OFFLINE] && !mode_reg[`MB_LEAVE_OFFLINE] && !REQ_BUSY) begin
        run_reg <= OFFLINE;
        OFFLINE_ENTERED <= (run_reg == PASSIVE_IDLE);
      end
    end
  end

  // Slave state machine; leave-master overrides the engine's progress
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      slave_reg <= AWAIT_PRM;
    end else if (mode_reg[`MB_LEAVE_MASTER]) begin
      slave_reg <= AWAIT_PRM;
    end else begin
      unique case (slave_reg)
        AWAIT_PRM: begin
          if (PRM_OK) begin
            slave_reg <= AWAIT_CFG;
          end
        end
        AWAIT_CFG: begin
          if (CFG_OK) begin
            slave_reg <= CYCLIC_EXCHANGE;
          end
        end
        CYCLIC_EXCHANGE: begin
          if (PRM_OK) begin
            slave_reg <= AWAIT_CFG;
          end
        end
        default: begin
          slave_reg <= AWAIT_PRM;
        end
      endcase
    end
  end

  // Buffer swap pulse on configuration accept
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      CFG_SWAP <= 1'b0;
    end else begin
      CFG_SWAP <= CFG_ACCEPT && mode_reg[`MB_SWAP_EN];
    end
  end

  // User watchdog counts down only while online
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wdog_cnt_reg <= `WDOG_PRESET_RESET;
      USER_WDOG_EXPIRED <= 1'b0;
    end else begin
      if (mode_reg[`MB_WDOG_RELOAD]) begin
        wdog_cnt_reg <= wdog_preset_reg;
      end else if (run_reg == PASSIVE_IDLE && wdog_cnt_reg != 16'h0) begin
        wdog_cnt_reg <= wdog_cnt_reg - 16'h1;
      end
      USER_WDOG_EXPIRED <= (run_reg == PASSIVE_IDLE) && (wdog_cnt_reg == 16'h0);
    end
  end

  // RAM address fold; the flag stays until the next leave-offline
  assign ram_over = RAM_ADDR >= `RAM_LIMIT;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      RAM_ADDR_MAPPED <= 11'h0;
      ram_violation_reg <= 1'b0;
    end else begin
      if (RAM_STROBE) begin
        RAM_ADDR_MAPPED <= ram_over ? RAM_ADDR - `RAM_FOLD : RAM_ADDR;
      end
      if (RAM_STROBE && ram_over) begin
        ram_violation_reg <= 1'b1;
      end else if (mode_reg[`MB_LEAVE_OFFLINE]) begin
        ram_violation_reg <= 1'b0;
      end
    end
  end

  // Interrupt line: end of interrupt drops it and a gap holds it off
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      irq_active_reg <= 1'b0;
      gap_cnt_reg <= 16'h0;
    end else if (mode_reg[`MB_END_OF_IRQ]) begin
      irq_active_reg <= 1'b0;
      gap_cnt_reg <= irq_cfg_reg[`IC_GAP_SCALE] ? GAP_LONG : GAP_SHORT;
    end else if (gap_cnt_reg != 16'h0) begin
      gap_cnt_reg <= gap_cnt_reg - 16'h1;
    end else if (IRQ_EVENT) begin
      irq_active_reg <= 1'b1;
    end
  end

  // Pin level; polarity zero means low-active, which edge-triggered inputs tolerate
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      IRQ_OUT <= 1'b1;
    end else begin
      IRQ_OUT <= irq_active_reg ~^ irq_cfg_reg[`IC_INT_POL];
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_set_write(int b);
    wr_set && APB_REQ.pwdata[b];
  endsequence

  sequence s_irq_release;
    mode_reg[`MB_END_OF_IRQ] ##1 !irq_active_reg;
  endsequence

  a_set_bit_swap: assert property (s_set_write(`MB_SWAP_EN) |=> mode_reg[`MB_SWAP_EN])
    else $error("swap enable not set");
  a_clear_bit_swap: assert property (wr_clr && !wr_set && APB_REQ.pwdata[`MB_SWAP_EN]
    |=> !mode_reg[`MB_SWAP_EN])
    else $error("swap enable not cleared");
  a_reserved_ignored: assert property ((wr_set || wr_clr) && APB_REQ.pwdata[5:0] == 6'h0
    && mode_reg == 6'h10 |=> mode_reg == 6'h10)
    else $error("reserved write changed mode");
  a_leave_offline_go: assert property (mode_reg[`MB_LEAVE_OFFLINE] && run_reg == OFFLINE
    |=> run_reg == PASSIVE_IDLE && TIMERS_START ##1 !TIMERS_START)
    else $error("leave offline failed");
  a_irq_drop: assert property (mode_reg[`MB_END_OF_IRQ] && !wr_set
    |-> s_irq_release ##1 IRQ_OUT != irq_cfg_reg[`IC_INT_POL])
    else $error("interrupt not dropped");
  a_irq_ack_clear: assert property (mode_reg[`MB_END_OF_IRQ] && !wr_set
    |=> !mode_reg[`MB_END_OF_IRQ])
    else $error("end of interrupt stuck");
  a_go_offline_done: assert property (mode_reg[`MB_GO_OFFLINE] && !REQ_BUSY
    && !mode_reg[`MB_LEAVE_OFFLINE] && !wr_set |=> run_reg == OFFLINE
    && !mode_reg[`MB_GO_OFFLINE])
    else $error("go offline failed");
  a_go_offline_wait: assert property (mode_reg[`MB_GO_OFFLINE] && REQ_BUSY
    && run_reg == PASSIVE_IDLE && !mode_reg[`MB_LEAVE_OFFLINE]
    |=> run_reg == PASSIVE_IDLE)
    else $error("offline before request ended");
  a_leave_master: assert property (mode_reg[`MB_LEAVE_MASTER] && !wr_set
    |=> slave_reg == AWAIT_PRM && !mode_reg[`MB_LEAVE_MASTER])
    else $error("leave master failed");
  a_cfg_swap_gate: assert property (CFG_ACCEPT
    |=> CFG_SWAP == $past(mode_reg[`MB_SWAP_EN]))
    else $error("swap gate wrong");
  a_wdog_reload: assert property (mode_reg[`MB_WDOG_RELOAD]
    |=> wdog_cnt_reg == $past(wdog_preset_reg))
    else $error("watchdog not reloaded");
  a_ram_fold: assert property (RAM_STROBE && ram_over
    |=> RAM_ADDR_MAPPED == $past(RAM_ADDR) - 11'h400 && status.ram_violation)
    else $error("ram fold wrong");
  a_gap_hold: assert property ($fell(irq_active_reg) && !irq_cfg_reg[`IC_GAP_SCALE]
    |-> !irq_active_reg [*8])
    else $error("interrupt gap too short");
  a_slave_code: assert property (status.slave_state != 2'b11)
    else $error("illegal slave code");
  a_read_status: assert property (setup_phase && !APB_REQ.pwrite
    && hit(APB_REQ.paddr, `IDX_STAT_HI) |=> PRDATA[7:4] == `RELEASE_NUM)
    else $error("release number wrong");

  // Cycles since the last interrupt acknowledge and the gap it asked for; checking aid only
  logic [16:0] since_ack_reg;
  logic [15:0] gap_need_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      since_ack_reg <= 17'h1ffff;
      gap_need_reg <= 16'h0;
    end else if (mode_reg[`MB_END_OF_IRQ]) begin
      since_ack_reg <= 17'h0;
      gap_need_reg <= irq_cfg_reg[`IC_GAP_SCALE] ? GAP_LONG : GAP_SHORT;
    end else if (since_ack_reg != 17'h1ffff) begin
      since_ack_reg <= since_ack_reg + 17'h1;
    end
  end

  // The line may come back only once the whole gap has passed, at either scale
  a_gap_counted: assert property ($rose(irq_active_reg)
    |-> since_ack_reg > {1'b0, gap_need_reg})
    else $error("interrupt back before gap ended");

  // Remaining self-clearing and side effects of the action bits
  a_leave_clears_go: assert property (mode_reg[`MB_LEAVE_OFFLINE] && !wr_set
    |=> !mode_reg[`MB_GO_OFFLINE] && !mode_reg[`MB_LEAVE_OFFLINE])
    else $error("leave offline left a request set");
  a_reload_clear: assert property (mode_reg[`MB_WDOG_RELOAD] && !wr_set
    |=> !mode_reg[`MB_WDOG_RELOAD])
    else $error("watchdog reload stuck");
  a_offline_pulse: assert property (OFFLINE_ENTERED |-> !status.passive_idle)
    else $error("offline pulse while idle");

  // No swap without an accept, and no address move below the limit
  a_swap_quiet: assert property (!CFG_ACCEPT |=> !CFG_SWAP)
    else $error("swap without accept");
  a_ram_pass: assert property (RAM_STROBE && !ram_over
    |=> RAM_ADDR_MAPPED == $past(RAM_ADDR))
    else $error("ram address moved below limit");

  // Slave state codes as the engine moves through them
  a_slave_to_cfg: assert property (slave_reg == AWAIT_PRM && PRM_OK
    && !mode_reg[`MB_LEAVE_MASTER] |=> status.slave_state == 2'b01)
    else $error("await configuration code wrong");
  a_slave_to_data: assert property (slave_reg == AWAIT_CFG && CFG_OK
    && !mode_reg[`MB_LEAVE_MASTER] |=> status.slave_state == 2'b10)
    else $error("cyclic exchange code wrong");

  // Low status byte shows the run state as it stood at the setup edge
  a_read_idle: assert property (setup_phase && !APB_REQ.pwrite
    && hit(APB_REQ.paddr, `IDX_STAT_LO) |=> PRDATA[0] == $past(status.passive_idle))
    else $error("idle flag read wrong");
endmodule

// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic CLK_SYS,
  // APB master side
  output modebank_pkg::apb_req_type APB_REQ,
  input wire logic PREADY
);
  import modebank_pkg::*;

  initial APB_REQ = '0;

  // One transfer; the request holds until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    APB_REQ.psel <= 1'b1;
    APB_REQ.penable <= 1'b0;
    APB_REQ.pwrite <= wr;
    APB_REQ.paddr <= {idx, 2'b00};
    APB_REQ.pwdata <= wd;
    @(posedge CLK_SYS);
    APB_REQ.penable <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    APB_REQ.psel <= 1'b0;
    APB_REQ.penable <= 1'b0;
    // Released data must not look like the last value
    APB_REQ.pwdata <= ~wd;
    @(posedge CLK_SYS);
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "modebank_cfg.svh"
module tb_top;
  import modebank_pkg::*;
  localparam int GAP_LONG = 100;
  typedef struct packed {logic err; logic [31:0] data;} note_type;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  apb_req_type apb_req;
  logic [31:0] prdata;
  logic pready, pslverr, timers_start, cfg_swap, wdog_expired, offline_entered, irq_out;
  logic req_busy = 1'b0, link_ind = 1'b0, diag_pend = 1'b0, irq_event = 1'b0;
  logic [3:0] pulses = 4'h0;
  logic [1:0] wdog_state = 2'h0;
  logic [3:0] baud_code = 4'h0;
  logic [10:0] ram_addr = 11'h000;
  logic [10:0] ram_mapped;
  note_type notes[$];
  note_type got;
  int fails = 0;
  int comparisons = 0;
  int seed = 50247;
  int n_start = 0, n_swap = 0, n_off = 0, cnt, gap;

  always #12.5 clk_sys = ~clk_sys;

  modebank #(.IRQ_GAP_LONG_CYCLES(GAP_LONG)) i_modebank (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .APB_REQ(apb_req), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .REQ_BUSY(req_busy),
    .LINK_IND_PENDING(link_ind), .DIAG_PENDING(diag_pend), .WDOG_STATE(wdog_state),
    .BAUD_CODE(baud_code), .PRM_OK(pulses[0]), .CFG_OK(pulses[1]),
    .CFG_ACCEPT(pulses[2]), .RAM_STROBE(pulses[3]), .RAM_ADDR(ram_addr),
    .RAM_ADDR_MAPPED(ram_mapped), .IRQ_EVENT(irq_event), .TIMERS_START(timers_start),
    .CFG_SWAP(cfg_swap), .USER_WDOG_EXPIRED(wdog_expired),
    .OFFLINE_ENTERED(offline_entered), .IRQ_OUT(irq_out));

  host_model i_host_model (.CLK_SYS(clk_sys), .APB_REQ(apb_req), .PREADY(pready));

  // Each completed read is judged against the oldest note
  always @(posedge clk_sys) begin
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite && pready === 1'b1) begin
      got = notes.pop_front();
      comparisons++;
      if (prdata !== got.data || pslverr !== got.err) begin
        fails++;
        $display("unexpected at %0t: read %h err %b", $time, prdata, pslverr);
      end
    end
  end

  // Pulse counters, so a missing or doubled pulse shows up later
  always @(posedge clk_sys) begin
    n_start <= n_start + int'(timers_start === 1'b1);
    n_swap <= n_swap + int'(cfg_swap === 1'b1);
    n_off <= n_off + int'(offline_entered === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    i_host_model.xfer(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] d, input logic e = 1'b0);
    notes.push_back({e, d});
    i_host_model.xfer(1'b0, idx, 32'h0);
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic pulse(input int b);
    pulses[b] <= 1'b1;
    tick(1);
    pulses[b] <= 1'b0;
    tick(2);
  endtask

  // Bounded wait; cnt tells how long the wait lasted
  task automatic wait_irq(input logic lvl);
    cnt = 0;
    while (irq_out !== lvl && cnt < 3000) begin
      tick(1);
      cnt++;
    end
  endtask

  function automatic logic [31:0] stat_lo(input logic idle, viol, input logic [1:0] ss);
    return {24'h0, wdog_state, ss, viol, diag_pend, link_ind, idle};
  endfunction

  task automatic end_of_test;
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  initial begin
    tick(4);
    rst_n <= 1'b1;
    chk(irq_out === 1'b1, "irq not low-active idle");
    rd(`IDX_MODE_SET, 32'h0);
    rd(`IDX_WDOG_PRESET, 32'h0000ffff);
    rd(10'h3ff, 32'h0, 1'b1);
    // Random engine status through both bytes; status writes are ignored
    for (int i = 0; i < 8; i++) begin
      cnt = $random(seed);
      link_ind <= cnt[0];
      diag_pend <= cnt[1];
      wdog_state <= 2'(cnt[3:2] % 3);
      baud_code <= 4'(cnt[7:4] % 10);
      tick(1);
      wr(`IDX_STAT_LO, 32'hff);
      rd(`IDX_STAT_LO, stat_lo(1'b0, 1'b0, 2'b00));
      rd(`IDX_STAT_HI, {24'h0, `RELEASE_NUM, baud_code});
    end
    // Leave-offline clears a waiting go-offline
    req_busy <= 1'b1;
    wr(`IDX_MODE_SET, 32'h4);
    rd(`IDX_MODE_SET, 32'h4);
    wr(`IDX_MODE_SET, 32'h1);
    rd(`IDX_MODE_CLR, 32'h0);
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b00));
    chk(n_start == 1, "timers not started once");
    // Go-offline waits for the running request
    wr(`IDX_MODE_SET, 32'h4);
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b00));
    req_busy <= 1'b0;
    tick(2);
    rd(`IDX_MODE_SET, 32'h0);
    rd(`IDX_STAT_LO, stat_lo(1'b0, 1'b0, 2'b00));
    chk(n_off == 1, "offline entry count");
    // The start pulse follows the action edge and is counted one edge later
    wr(`IDX_MODE_SET, 32'h1);
    tick(2);
    chk(n_start == 2, "restart not retriggered");
    // Independent bits, reserved bits ignored
    wr(`IDX_MODE_SET, 32'hd0);
    wr(`IDX_MODE_CLR, 32'hc0);
    rd(`IDX_MODE_SET, 32'h10);
    // Swap only while enabled
    for (int e = 0; e < 2; e++) begin
      pulse(2);
      chk(n_swap == 1, "swap count");
      wr(`IDX_MODE_CLR, 32'h10);
    end
    // Slave machine states and leave-master
    pulse(0);
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b01));
    pulse(1);
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b10));
    wr(`IDX_MODE_SET, 32'h8);
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b00));
    // RAM window at and below the limit
    ram_addr <= 11'd1535;
    pulse(3);
    chk(ram_mapped === 11'd1535, "ram map below limit");
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b0, 2'b00));
    ram_addr <= 11'd1536;
    pulse(3);
    chk(ram_mapped === 11'd512, "ram fold");
    rd(`IDX_STAT_LO, stat_lo(1'b1, 1'b1, 2'b00));
    // Interrupt level, end of interrupt and gap at both scales
    for (int m = 0; m < 2; m++) begin
      gap = (m == 0) ? `IRQ_GAP_SHORT_CYC : GAP_LONG;
      wr(`IDX_IRQ_CFG, 32'(m * 3));
      irq_event <= 1'b1;
      wait_irq(m[0]);
      chk(irq_out === m[0], "irq not active");
      // The pin drops two edges after the write, so wait for that before timing the gap
      wr(`IDX_MODE_SET, 32'h2);
      wait_irq(!m[0]);
      chk(irq_out === !m[0], "irq not dropped");
      wait_irq(m[0]);
      chk(cnt >= gap && cnt <= gap + 8, "irq gap");
      irq_event <= 1'b0;
      wr(`IDX_MODE_SET, 32'h2);
      rd(`IDX_MODE_SET, 32'h0);
    end
    // User watchdog reload
    wr(`IDX_WDOG_PRESET, 32'd20);
    wr(`IDX_MODE_SET, 32'h20);
    cnt = 0;
    while (wdog_expired !== 1'b1 && cnt < 100) begin
      tick(1);
      cnt++;
    end
    chk(cnt >= 14 && cnt <= 24, "watchdog reload time");
    // Expiry is registered, so it falls one edge after the reload lands
    wr(`IDX_MODE_SET, 32'h20);
    tick(2);
    chk(wdog_expired === 1'b0, "reload not retriggered");
    rd(`IDX_MODE_SET, 32'h0);
    tick(2);
    end_of_test();
  end
endmodule
